// ---- verilog/erm_consts.svh ----
// Constants for the event request and masking block.
`ifndef ERM_CONSTS_SVH
`define ERM_CONSTS_SVH
`define ERM_OFF_NET_MASK   16'h0200
`define ERM_OFF_APP_MASK   16'h0204
`define ERM_OFF_NET_REQ    16'h0210
`define ERM_NET_MASK_RST   16'h0000
`define ERM_APP_MASK_RST   32'h00FFFF0F
`define ERM_BIT_LATCH      0
`define ERM_BIT_DL         2
`define ERM_BIT_AL         3
`define ERM_BIT_SYNC_LO    4
`define ERM_BIT_APP_SYNC   8
`define ERM_NUM_SYNC       8
`endif

// ---- verilog/erm_pkg.sv ----
// Types for the event request and masking block.
package erm_pkg;
  // One byte-wide register access from either side.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } erm_acc_t;

  // Status-change events from the rest of the controller.
  typedef struct packed {
    logic [7:0] sync_pending;
    logic       al_change;
    logic       al_status_rd;
    logic       dl_change;
    logic       dl_status_rd;
    logic       latch_change;
    logic       latch_empty_net;
  } erm_evt_t;
endpackage : erm_pkg

// ---- verilog/erm_byte_reg.sv ----
// One byte lane of a little-endian register with its own reset value.
`timescale 1ns/100ps
module erm_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  // Write strobe and data
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  // Stored byte
  output logic      [7:0] q_out
);
  logic [7:0] byte_q;
  logic [7:0] byte_d;

  // Loads the lane on a write strobe.
  always_comb
  begin
    byte_d = wr_in ? wdata_in : byte_q;
  end

  // Registers the lane.
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      byte_q <= RESET_VAL;
    else
      byte_q <= byte_d;
  end

  assign q_out = byte_q;
endmodule : erm_byte_reg

// ---- verilog/erm_event_mask.sv ----
// Network and application event request and mask logic.
`timescale 1ns/100ps
`include "erm_consts.svh"
module erm_event_mask (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  // Network-side byte access
  input  wire erm_pkg::erm_acc_t net_acc_in,
  // Host-interface-side byte access
  input  wire erm_pkg::erm_acc_t host_acc_in,
  // Status events from the controller
  input  wire erm_pkg::erm_evt_t evt_in,
  input  wire logic [31:0]      app_request_in,
  // Read data, valid one cycle after a read
  output logic      [7:0]       net_rdata_out,
  output logic      [7:0]       host_rdata_out,
  // Masked event outputs
  output logic      [15:0]      frame_event_out,
  output logic                  host_irq_out
);
  // Register offsets at the width of the address path, reset values at the width of each mask.
  localparam logic [15:0] NM_OFF = `ERM_OFF_NET_MASK;
  localparam logic [15:0] AM_OFF = `ERM_OFF_APP_MASK;
  localparam logic [15:0] RQ_OFF = `ERM_OFF_NET_REQ;
  localparam logic [15:0] NM_RST = `ERM_NET_MASK_RST;
  localparam logic [31:0] AM_RST = `ERM_APP_MASK_RST;

  // Mask contents, assembled from the byte lanes.
  logic [15:0] net_mask;
  logic [31:0] app_mask;
  // Byte write strobes, one per lane, from the side that owns each mask.
  logic [1:0]  nm_wr;
  logic [3:0]  am_wr;
  // Set and clear terms of the three sticky request flags.
  logic        al_set;
  logic        al_clr;
  logic        dl_set;
  logic        dl_clr;
  logic        lt_set;
  logic        lt_clr;
  // Network event request register.
  logic [15:0] net_req_q;
  logic [15:0] net_req_d;
  // Masked outputs toward frames and the host.
  logic [15:0] frame_event_q;
  logic [15:0] frame_event_d;
  logic        host_irq_q;
  logic        host_irq_d;
  // Read data of each side.
  logic [7:0]  net_rdata_q;
  logic [7:0]  net_rdata_d;
  logic [7:0]  host_rdata_q;
  logic [7:0]  host_rdata_d;

  // Network mask strobes. A host write to these bytes decodes to nothing, so the
  // host side can only read this mask.
  always_comb
  begin
    for (int n = 0; n < 2; n++)
    begin
      nm_wr[n] = net_acc_in.wr && (net_acc_in.addr == NM_OFF + 16'(n));
    end
  end

  // Application mask strobes. Network writes to these bytes are ignored, so the
  // network side can only read this mask.
  always_comb
  begin
    for (int n = 0; n < 4; n++)
    begin
      am_wr[n] = host_acc_in.wr && (host_acc_in.addr == AM_OFF + 16'(n));
    end
  end

  // Network mask lanes, lowest address in the least significant byte.
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_nm
      erm_byte_reg #(.RESET_VAL(NM_RST[8*i +: 8])) u_lane (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .wr_in      (nm_wr[i]),
        .wdata_in   (net_acc_in.wdata),
        .q_out      (net_mask[8*i +: 8])
      );
    end
    // Application mask lanes, lowest address in the least significant byte.
    for (i = 0; i < 4; i++)
    begin : g_am
      erm_byte_reg #(.RESET_VAL(AM_RST[8*i +: 8])) u_lane (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .wr_in      (am_wr[i]),
        .wdata_in   (host_acc_in.wdata),
        .q_out      (app_mask[8*i +: 8])
      );
    end
  endgenerate

  // Byte read mux shared by both sides; every register here reads from both,
  // and an unmapped address reads as zero.
  function automatic logic [7:0] rd_byte(input logic [15:0] a, input logic [15:0] nm,
                                         input logic [31:0] am, input logic [15:0] rq);
    logic [7:0] r;
    r = 8'h00;
    if (a[15:1] == NM_OFF[15:1])
    begin
      r = a[0] ? nm[15:8] : nm[7:0];
    end
    else if (a[15:2] == AM_OFF[15:2])
    begin
      case (a[1:0])
        2'h0:    r = am[7:0];
        2'h1:    r = am[15:8];
        2'h2:    r = am[23:16];
        default: r = am[31:24];
      endcase
    end
    else if (a[15:1] == RQ_OFF[15:1])
    begin
      r = a[0] ? rq[15:8] : rq[7:0];
    end
    return r;
  endfunction : rd_byte

  // Set and clear terms. A clear only counts when no new change arrives in the
  // same cycle, so an event that lands during the status read is not lost.
  always_comb
  begin
    al_set = evt_in.al_change;
    al_clr = evt_in.al_status_rd && !evt_in.al_change;
    dl_set = evt_in.dl_change;
    dl_clr = evt_in.dl_status_rd && !evt_in.dl_change;
    lt_set = evt_in.latch_change;
    lt_clr = evt_in.latch_empty_net && !evt_in.latch_change;
  end

  // Next request state. Reserved bits stay zero; the channel mirrors follow their
  // sources with one cycle of lag.
  always_comb
  begin
    net_req_d = 16'h0000;
    net_req_d[`ERM_BIT_SYNC_LO +: `ERM_NUM_SYNC] = evt_in.sync_pending;
    net_req_d[`ERM_BIT_AL] = al_set || (net_req_q[`ERM_BIT_AL] && !al_clr);
    net_req_d[`ERM_BIT_DL] = dl_set || (net_req_q[`ERM_BIT_DL] && !dl_clr);
    net_req_d[`ERM_BIT_LATCH] = lt_set || (net_req_q[`ERM_BIT_LATCH] && !lt_clr);
  end

  // Registers the request state.
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      net_req_q <= 16'h0000;
    end
    else
    begin
      net_req_q <= net_req_d;
    end
  end

  // Masked outputs. The frame field carries only the enabled request bits, and
  // the host line rises for any enabled application request.
  always_comb
  begin
    frame_event_d = net_req_q & net_mask;
    host_irq_d = |(app_request_in & app_mask);
  end

  // Registers the masked outputs so that each top-level output comes from a flop.
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      frame_event_q <= 16'h0000;
      host_irq_q    <= 1'b0;
    end
    else
    begin
      frame_event_q <= frame_event_d;
      host_irq_q    <= host_irq_d;
    end
  end

  // Read data: the addressed byte for one cycle after a read, zero otherwise.
  always_comb
  begin
    net_rdata_d = 8'h00;
    host_rdata_d = 8'h00;
    if (net_acc_in.rd)
    begin
      net_rdata_d = rd_byte(net_acc_in.addr, net_mask, app_mask, net_req_q);
    end
    if (host_acc_in.rd)
    begin
      host_rdata_d = rd_byte(host_acc_in.addr, net_mask, app_mask, net_req_q);
    end
  end

  // Registers the read data of both sides.
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      net_rdata_q  <= 8'h00;
      host_rdata_q <= 8'h00;
    end
    else
    begin
      net_rdata_q  <= net_rdata_d;
      host_rdata_q <= host_rdata_d;
    end
  end

  // Top-level outputs, each straight from its flip-flop.
  assign frame_event_out = frame_event_q;
  assign host_irq_out    = host_irq_q;
  assign net_rdata_out   = net_rdata_q;
  assign host_rdata_out  = host_rdata_q;
endmodule : erm_event_mask

// ---- tb/erm_props.sv ----
// Checker for the event request and mask block.
`timescale 1ns/100ps
module erm_props (
  input wire logic              clk_sys_in,
  input wire logic              reset_in,
  input wire erm_pkg::erm_acc_t net_acc_in,
  input wire erm_pkg::erm_acc_t host_acc_in,
  input wire erm_pkg::erm_evt_t evt_in,
  input wire logic [31:0]       app_request_in,
  input wire logic [7:0]        net_rdata_out,
  input wire logic [7:0]        host_rdata_out,
  input wire logic [15:0]       frame_event_out,
  input wire logic              host_irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Network read of the low request byte.
  wire rq = net_acc_in.rd && net_acc_in.addr == 16'h0210;
  a_net_idle: assert property (!net_acc_in.rd |=> net_rdata_out == 8'h00)
    else $error("net read data not idle");
  a_host_idle: assert property (!host_acc_in.rd |=> host_rdata_out == 8'h00)
    else $error("host read data not idle");
  a_frame_rsvd: assert property (frame_event_out[15:12] == 4'h0 && !frame_event_out[1])
    else $error("reserved frame bit set");
  a_frame_sync: assert property (
    (frame_event_out[11:4] & ~$past(evt_in.sync_pending, 2)) == 8'h00)
    else $error("frame sync bit without pending");
  a_irq_quiet: assert property (app_request_in == 32'h0 |=> !host_irq_out)
    else $error("interrupt without request");
  a_latch_set: assert property (evt_in.latch_change ##1 rq |=> net_rdata_out[0])
    else $error("latch event not seen");
  a_dl_set: assert property (evt_in.dl_change ##1 rq |=> net_rdata_out[2])
    else $error("link event not seen");
  a_al_clear: assert property (
    (evt_in.al_status_rd && !evt_in.al_change) ##1 rq |=> !net_rdata_out[3])
    else $error("status event not cleared");
  a_req_rsvd: assert property (
    net_acc_in.rd && net_acc_in.addr == 16'h0211 |=> net_rdata_out[7:4] == 4'h0)
    else $error("reserved request bit set");
endmodule : erm_props

bind erm_event_mask erm_props i_props (.clk_sys_in, .reset_in, .net_acc_in, .host_acc_in,
  .evt_in, .app_request_in, .net_rdata_out, .host_rdata_out, .frame_event_out, .host_irq_out);

// ---- tb/erm_far_model.sv ----
// Status sources that stand beyond the event block.
`timescale 1ns/100ps
module erm_far_model (
  // Requested pattern and events shown to the block
  input  wire erm_pkg::erm_evt_t want_in,
  output erm_pkg::erm_evt_t      evt_out
);
  // Sources change only off the sampling edge, as the bench does.
  assign evt_out = want_in;
endmodule : erm_far_model

// ---- tb/test_erm_event_mask.sv ----
// Self-checking bench for the event request and mask block.
`timescale 1ns/100ps
module test_erm_event_mask;
  logic              clk_sys_in = 1'b0;
  logic              reset_in = 1'b1;
  erm_pkg::erm_acc_t na = '0, ha = '0;
  erm_pkg::erm_evt_t ev = '0, evt;
  logic [31:0]       app = 32'h0;
  logic [7:0]        nrd, hrd;
  logic [15:0]       fev;
  logic              irq;
  int                n_errors = 0, total_checks = 0;
  // Rows: host flag, address, byte expected after reset.
  logic [24:0] rows [8] = '{25'h0020000, 25'h0020100, 25'h002040F, 25'h00205FF,
                            25'h00206FF, 25'h1020700, 25'h102040F, 25'h0030000};
  erm_event_mask i_dut (.clk_sys_in, .reset_in, .net_acc_in(na), .host_acc_in(ha),
    .evt_in(evt), .app_request_in(app), .net_rdata_out(nrd), .host_rdata_out(hrd),
    .frame_event_out(fev), .host_irq_out(irq));
  erm_far_model i_far (.want_in(ev), .evt_out(evt));
  // Clock at 40 MHz.
  always #12.5 clk_sys_in = ~clk_sys_in;
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // One byte access, taken at the rising edge between two falling edges.
  task acc(input logic h, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    if (h) ha = '{~w, w, a, d};
    else na = '{~w, w, a, d};
    @(negedge clk_sys_in);
    na = '0;
    ha = '0;
  endtask : acc
  task conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Watchdog far beyond the expected run.
  initial
  begin
    #200us;
    n_errors++;
    conclude;
  end
  initial
  begin
    repeat (20) @(negedge clk_sys_in);
    reset_in = 1'b0;
    foreach (rows[i])
    begin
      acc(rows[i][24], 1'b0, rows[i][23:8], 8'h00);
      chk("reset", rows[i][7:0], rows[i][24] ? hrd : nrd);
    end
    acc(0, 1, 16'h0200, 8'h01);
    acc(1, 1, 16'h0200, 8'hFF);
    acc(1, 0, 16'h0200, 8'h00);
    chk("net mask", 8'h01, hrd);
    acc(0, 1, 16'h0204, 8'h00);
    acc(1, 1, 16'h0204, 8'h01);
    acc(0, 0, 16'h0204, 8'h00);
    chk("app mask", 8'h01, nrd);
    app = 32'h2;
    repeat (2) @(negedge clk_sys_in);
    chk("irq off", 1'b0, irq);
    app = 32'h100;
    repeat (2) @(negedge clk_sys_in);
    chk("irq on", 1'b1, irq);
    ev = 14'h000A; // Link and latch changes.
    acc(0, 0, 16'h0210, 8'h00);
    chk("req set", 8'h05, nrd);
    ev = '0;
    repeat (2) @(negedge clk_sys_in);
    chk("frame", 16'h0001, fev);
    ev = 14'h0025; // Status change, link read, latches empty.
    acc(0, 0, 16'h0210, 8'h00);
    chk("req clear", 8'h08, nrd);
    ev = 14'h2050; // Channels 0 and 7 pending, status read.
    acc(0, 0, 16'h0210, 8'h00);
    chk("req low", 8'h10, nrd);
    acc(0, 0, 16'h0211, 8'h00);
    chk("req high", 8'h08, nrd);
    // Link change and link status read together: the set must win.
    ev = 14'h204C;
    acc(0, 0, 16'h0210, 8'h00);
    chk("set wins", 8'h14, nrd);
    // Mid-run reset brings masks and outputs back to their defaults.
    ev = '0;
    reset_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    chk("reset frame", 16'h0000, fev);
    chk("reset irq", 1'b0, irq);
    reset_in = 1'b0;
    acc(1, 0, 16'h0204, 8'h00);
    chk("reset app", 8'h0F, hrd);
    acc(0, 0, 16'h0200, 8'h00);
    chk("reset net", 8'h00, nrd);
    chk("irq again", 1'b1, irq);
    conclude;
  end
endmodule : test_erm_event_mask
